//--- hdl/sov_synth_ctrl.sv
// synth pin override, oscillator trim and synth reset control
// Function
// - override bit 7 selects registers over pins
// - pin mode: pins drive enable, ref, outputs
// - bits 5:4 choose second output divide
// - override off: output fields ignored, pins rule
// - second output only when first runs
// - bits 3:2 choose first output divide
// - bit 1 selects single-ended reference input
// - bit 0 enables synthesizer under override
// - trim auto-filled by calibration, readable, writable
// - reset release starts calibration when enabled
// - completion flag set when done or skipped
`timescale 1ns/1ps
`include "sov_params.svh"

module sov_synth_ctrl #(
   parameter int SETTLE_UNIT_CYC = `SOV_SETTLE_UNIT_CYC
) (
   // clock and reset
   input  wire logic                    i_core_clk,
   input  wire logic                    i_reset,
   // register access port
   input  wire logic                    i_reg_wr,
   input  wire logic                    i_reg_rd,
   input  wire logic [7:0]              i_reg_addr,
   input  wire logic [7:0]              i_reg_wdata,
   output logic      [7:0]              o_reg_rdata,
   // configuration pins
   input  wire logic                    i_synth_enable_pin,
   input  wire logic                    i_single_ended_ref_pin,
   input  wire logic                    i_clock_config_pin_a,
   input  wire logic                    i_clock_config_pin_b,
   // frequency detector
   input  wire logic                    i_osc_fast,
   // synthesizer controls
   output logic                         o_synth_enable,
   output logic                         o_single_ended_ref_select,
   output sov_pkg::sov_refout_type      o_first_refout_select,
   output sov_pkg::sov_refout_type      o_second_refout_select,
   output logic      [6:0]              o_oscillator_trim_field,
   output logic                         o_synth_reset_bit,
   output logic                         o_osc_calibration_complete
);
   import sov_pkg::*;

   sov_top_type st;
   sov_top_type next_st;
   logic [6:0]  cal_trim;
   logic        cal_busy;
   logic        cal_done;

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_addr);
      hit = (addr == reg_addr);
   endfunction : hit

   sov_cal_engine #(
      .UNIT_CYC (SETTLE_UNIT_CYC)
   ) u_cal (
      .i_core_clk   (i_core_clk),
      .i_reset      (i_reset),
      .i_start      (st.cal_start),
      .i_abort      (st.reset_bit),
      .i_settle_sel (st.cal_stl),
      .i_osc_fast   (i_osc_fast),
      .o_trim       (cal_trim),
      .o_busy       (cal_busy),
      .o_done       (cal_done)
   );

   always_comb begin
      next_st           = st;
      next_st.cal_start = 1'b0;
      // register writes; reserved bits are not stored and read as zero
      if (i_reg_wr) begin
         if (hit(i_reg_addr, `SOV_ADDR_PIN_OVERRIDE)) begin
            next_st.ovr_en     = i_reg_wdata[`SOV_OVR_EN_BIT];
            next_st.ovr_second =
               sov_refout_type'(i_reg_wdata[`SOV_OVR_SECOND_HI:`SOV_OVR_SECOND_LO]);
            next_st.ovr_first  =
               sov_refout_type'(i_reg_wdata[`SOV_OVR_FIRST_HI:`SOV_OVR_FIRST_LO]);
            next_st.ovr_se     = i_reg_wdata[`SOV_OVR_SE_BIT];
            next_st.ovr_pll_en = i_reg_wdata[`SOV_OVR_PLL_EN_BIT];
         end
         // software trim write only outside a run, a run would overwrite it anyway
         if (hit(i_reg_addr, `SOV_ADDR_OSC_TRIM) && !cal_busy) begin
            next_st.trim = i_reg_wdata[6:0];
         end
         if (hit(i_reg_addr, `SOV_ADDR_RESET_CTRL)) begin
            next_st.reset_bit = i_reg_wdata[0];
            if (i_reg_wdata[0]) begin
               next_st.cal_complete = 1'b0;
            end else if (st.reset_bit) begin
               // release: run calibration, or report it skipped
               next_st.cal_start    = st.cal_en;
               next_st.cal_complete = !st.cal_en;
            end
         end
         if (hit(i_reg_addr, `SOV_ADDR_CAL_CTRL)) begin
            next_st.cal_stl = i_reg_wdata[`SOV_CAL_STL_HI:`SOV_CAL_STL_LO];
            next_st.cal_en  = i_reg_wdata[`SOV_CAL_EN_BIT];
         end
      end
      // engine owns the trim while it runs
      if (cal_busy) begin
         next_st.trim = cal_trim;
      end
      if (cal_done) begin
         next_st.trim         = cal_trim;
         next_st.cal_complete = 1'b1;
      end
      // control selection from the next register values, so a change acts at once
      if (next_st.ovr_en) begin
         next_st.synth_enable = next_st.ovr_pll_en;
         next_st.se_select    = next_st.ovr_se;
         next_st.first_sel    = next_st.ovr_first;
         next_st.second_sel   = next_st.ovr_second;
      end else begin
         next_st.synth_enable = i_synth_enable_pin;
         next_st.se_select    = i_single_ended_ref_pin;
         // pin code {b,a} picks the first divide; second runs div1 only at code 3
         next_st.first_sel    =
            sov_refout_type'({i_clock_config_pin_b, i_clock_config_pin_a});
         next_st.second_sel   = (i_clock_config_pin_b && i_clock_config_pin_a) ?
            SOV_REF_DIV1 : SOV_REF_OFF;
      end
      // second output never runs alone
      if (next_st.first_sel == SOV_REF_OFF) begin
         next_st.second_sel = SOV_REF_OFF;
      end
      // registered read data; unmapped offsets read zero
      if (i_reg_rd) begin
         unique case (i_reg_addr)
            `SOV_ADDR_PIN_OVERRIDE: next_st.rdata = {st.ovr_en, 1'b0, st.ovr_second,
                                                     st.ovr_first, st.ovr_se, st.ovr_pll_en};
            `SOV_ADDR_OSC_TRIM:     next_st.rdata = {1'b0, st.trim};
            `SOV_ADDR_RESET_CTRL:   next_st.rdata = {7'h00, st.reset_bit};
            `SOV_ADDR_CAL_CTRL:     next_st.rdata = {1'b0, st.cal_stl, 3'h0, st.cal_en};
            `SOV_ADDR_CAL_STATUS:   next_st.rdata = {7'h00, st.cal_complete};
            default:                next_st.rdata = 8'h00;
         endcase
      end
   end

   // state register
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         st            <= '0;
         st.trim       <= `SOV_RST_TRIM;
         st.reset_bit  <= `SOV_RST_RESET_BIT;
         st.cal_stl    <= `SOV_RST_CAL_STL;
         st.cal_en     <= `SOV_RST_CAL_EN;
      end else begin
         st <= next_st;
      end
   end

   assign o_reg_rdata                = st.rdata;
   assign o_synth_enable             = st.synth_enable;
   assign o_single_ended_ref_select  = st.se_select;
   assign o_first_refout_select      = st.first_sel;
   assign o_second_refout_select     = st.second_sel;
   assign o_oscillator_trim_field    = st.trim;
   assign o_synth_reset_bit          = st.reset_bit;
   assign o_osc_calibration_complete = st.cal_complete;

   AST_OVR_ENABLE: assert property (@(posedge i_core_clk) disable iff (i_reset)
      st.ovr_en |-> (o_synth_enable == st.ovr_pll_en && o_single_ended_ref_select == st.ovr_se))
      else $error("override enable or ref select not taken from register");
   AST_OVR_FIRST: assert property (@(posedge i_core_clk) disable iff (i_reset)
      st.ovr_en |-> o_first_refout_select == st.ovr_first)
      else $error("first output not taken from register");
   AST_OVR_SECOND: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (st.ovr_en && st.ovr_first != SOV_REF_OFF) |-> o_second_refout_select == st.ovr_second)
      else $error("second output not taken from register");
   AST_PIN_MODE: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (!next_st.ovr_en && !i_reg_wr) |=>
         (o_synth_enable == $past(i_synth_enable_pin) &&
          o_first_refout_select == sov_refout_type'({$past(i_clock_config_pin_b),
                                                     $past(i_clock_config_pin_a)})))
      else $error("pin mode outputs do not follow pins");
   AST_SECOND_NEEDS_FIRST: assert property (@(posedge i_core_clk) disable iff (i_reset)
      o_first_refout_select == SOV_REF_OFF |-> o_second_refout_select == SOV_REF_OFF)
      else $error("second output runs without the first");
   AST_RELEASE_STARTS_CAL: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (i_reg_wr && i_reg_addr == 8'h5C && !i_reg_wdata[0] && st.reset_bit && st.cal_en)
         |-> ##2 cal_busy)
      else $error("reset release did not start calibration");
   AST_SKIP_COMPLETES: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (i_reg_wr && i_reg_addr == 8'h5C && !i_reg_wdata[0] && st.reset_bit && !st.cal_en)
         |=> o_osc_calibration_complete)
      else $error("skipped calibration not reported complete");
   AST_TRIM_READBACK: assert property (@(posedge i_core_clk) disable iff (i_reset)
      cal_done |=> (o_oscillator_trim_field == $past(cal_trim) && o_osc_calibration_complete))
      else $error("calibrated trim not kept");
   AST_OVR_SWITCH: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (i_reg_wr && i_reg_addr == 8'h58 && i_reg_wdata[7]) |=> o_synth_enable == $past(i_reg_wdata[0]))
      else $error("override write not applied next cycle");

endmodule : sov_synth_ctrl

//--- inc/sov_params.svh
// offsets, field positions, reset values and timing counts of the synth control block
`ifndef SOV_PARAMS_SVH
`define SOV_PARAMS_SVH

// register offsets
`define SOV_ADDR_PIN_OVERRIDE   8'h58
`define SOV_ADDR_OSC_TRIM       8'h59
`define SOV_ADDR_RESET_CTRL     8'h5C
`define SOV_ADDR_CAL_CTRL       8'h5D
`define SOV_ADDR_CAL_STATUS     8'h5E

// field positions of the pin override register
`define SOV_OVR_EN_BIT          7
`define SOV_OVR_SECOND_HI       5
`define SOV_OVR_SECOND_LO       4
`define SOV_OVR_FIRST_HI        3
`define SOV_OVR_FIRST_LO        2
`define SOV_OVR_SE_BIT          1
`define SOV_OVR_PLL_EN_BIT      0

// field positions of the calibration control register
`define SOV_CAL_STL_HI          6
`define SOV_CAL_STL_LO          4
`define SOV_CAL_EN_BIT          0

// reset values
`define SOV_RST_OVERRIDE        8'h00
`define SOV_RST_TRIM            7'h00
`define SOV_RST_RESET_BIT       1'h0
`define SOV_RST_CAL_STL         3'h4
`define SOV_RST_CAL_EN          1'h0
`define SOV_TRIM_MIDSCALE       7'h40

// settle time per calibration step, unit of the settle field
`define SOV_CLK_PERIOD_NS       40
`define SOV_SETTLE_UNIT_NS      400
`define SOV_SETTLE_UNIT_CYC     ((`SOV_SETTLE_UNIT_NS + `SOV_CLK_PERIOD_NS - 1) / `SOV_CLK_PERIOD_NS)

`endif

//--- inc/sov_pkg.sv
// types of the synth override and reset control block
package sov_pkg;

   // calibration engine states, one-hot
   typedef enum logic [2:0] {
      SOV_CAL_IDLE   = 3'h1,
      SOV_CAL_SETTLE = 3'h2,
      SOV_CAL_DECIDE = 3'h4
   } sov_cal_state_type;

   // 2-bit divided-reference output function
   typedef enum logic [1:0] {
      SOV_REF_OFF  = 2'h0,
      SOV_REF_DIV1 = 2'h1,
      SOV_REF_DIV2 = 2'h2,
      SOV_REF_DIV4 = 2'h3
   } sov_refout_type;

   // calibration engine state
   typedef struct packed {
      sov_cal_state_type state;
      logic [6:0]        trim;
      logic [2:0]        bit_idx;
      logic [15:0]       count;
      logic              busy;
      logic              done;
   } sov_cal_type;

   // top state
   typedef struct packed {
      logic              ovr_en;
      sov_refout_type    ovr_second;
      sov_refout_type    ovr_first;
      logic              ovr_se;
      logic              ovr_pll_en;
      logic [6:0]        trim;
      logic              reset_bit;
      logic [2:0]        cal_stl;
      logic              cal_en;
      logic              cal_complete;
      logic              cal_start;
      logic              synth_enable;
      logic              se_select;
      sov_refout_type    first_sel;
      sov_refout_type    second_sel;
      logic [7:0]        rdata;
   } sov_top_type;

endpackage : sov_pkg

//--- hdl/sov_cal_engine.sv
// oscillator trim calibration engine, binary search on the trim code
`timescale 1ns/1ps
`include "sov_params.svh"

module sov_cal_engine #(
   parameter int UNIT_CYC = `SOV_SETTLE_UNIT_CYC
) (
   // clock and reset
   input  wire logic       i_core_clk,
   input  wire logic       i_reset,
   // control
   input  wire logic       i_start,
   input  wire logic       i_abort,
   input  wire logic [2:0] i_settle_sel,
   // oscillator faster than target, from the frequency detector
   input  wire logic       i_osc_fast,
   // results
   output logic [6:0]      o_trim,
   output logic            o_busy,
   output logic            o_done
);
   import sov_pkg::*;

   sov_cal_type st;
   sov_cal_type next_st;

   // settle wait per step grows with the settle field
   function automatic logic [15:0] settle_count(input logic [2:0] sel);
      settle_count = 16'(UNIT_CYC * (int'(sel) + 1));
   endfunction : settle_count

   // one step per trim bit, msb first; settle before each decision
   always_comb begin
      next_st      = st;
      next_st.done = 1'b0;
      unique case (st.state)
         SOV_CAL_IDLE: begin
            if (i_start && !i_abort) begin
               next_st.state   = SOV_CAL_SETTLE;
               next_st.trim    = `SOV_TRIM_MIDSCALE;
               next_st.bit_idx = 3'h6;
               next_st.count   = settle_count(i_settle_sel);
               next_st.busy    = 1'b1;
            end
         end
         SOV_CAL_SETTLE: begin
            if (st.count <= 16'h0001) begin
               next_st.state = SOV_CAL_DECIDE;
            end else begin
               next_st.count = st.count - 16'h0001;
            end
         end
         SOV_CAL_DECIDE: begin
            // too fast means this bit overshoots, so drop it
            if (i_osc_fast) begin
               next_st.trim[st.bit_idx] = 1'b0;
            end
            if (st.bit_idx == 3'h0) begin
               next_st.state = SOV_CAL_IDLE;
               next_st.busy  = 1'b0;
               next_st.done  = 1'b1;
            end else begin
               next_st.bit_idx               = st.bit_idx - 3'h1;
               next_st.trim[st.bit_idx - 3'h1] = 1'b1;
               next_st.count                 = settle_count(i_settle_sel);
               next_st.state                 = SOV_CAL_SETTLE;
            end
         end
      endcase
      // synth reset kills a run at once
      if (i_abort) begin
         next_st.state = SOV_CAL_IDLE;
         next_st.busy  = 1'b0;
         next_st.done  = 1'b0;
      end
   end

   // state register
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         st       <= '0;
         st.state <= SOV_CAL_IDLE;
      end else begin
         st <= next_st;
      end
   end

   assign o_trim = st.trim;
   assign o_busy = st.busy;
   assign o_done = st.done;

   AST_CAL_DONE_ENDS_RUN: assert property (@(posedge i_core_clk) disable iff (i_reset)
      o_done |-> !o_busy && $past(o_busy))
      else $error("calibration done without a run ending");
   AST_CAL_START_MIDSCALE: assert property (@(posedge i_core_clk) disable iff (i_reset)
      (st.state == SOV_CAL_IDLE && i_start && !i_abort) |=> (o_busy && o_trim == 7'h40))
      else $error("calibration did not start at midscale");

endmodule : sov_cal_engine

//--- verif/tb_sov_synth_ctrl.sv
// self-checking bench for the synth override, trim and reset control block
`timescale 1ns/1ps
`include "sov_params.svh"

module tb_sov_synth_ctrl;
   import sov_pkg::*;

   // trim code at which the modelled oscillator reaches its target
   localparam logic [6:0] TARGET = 7'h35;

   logic                 i_core_clk;
   logic                 i_reset;
   logic                 i_reg_wr;
   logic                 i_reg_rd;
   logic [7:0]           i_reg_addr;
   logic [7:0]           i_reg_wdata;
   logic [7:0]           o_reg_rdata;
   logic                 i_synth_enable_pin;
   logic                 i_single_ended_ref_pin;
   logic                 i_clock_config_pin_a;
   logic                 i_clock_config_pin_b;
   logic                 i_osc_fast;
   logic                 o_synth_enable;
   logic                 o_single_ended_ref_select;
   sov_refout_type       o_first_refout_select;
   sov_refout_type       o_second_refout_select;
   logic [6:0]           o_oscillator_trim_field;
   logic                 o_synth_reset_bit;
   logic                 o_osc_calibration_complete;
   int                   n_fail;
   int                   comparisons;
   logic [7:0]           rv;

   // short settle unit keeps calibration runs brief
   sov_synth_ctrl #(.SETTLE_UNIT_CYC(1)) uut (
      .i_core_clk                 (i_core_clk),
      .i_reset                    (i_reset),
      .i_reg_wr                   (i_reg_wr),
      .i_reg_rd                   (i_reg_rd),
      .i_reg_addr                 (i_reg_addr),
      .i_reg_wdata                (i_reg_wdata),
      .o_reg_rdata                (o_reg_rdata),
      .i_synth_enable_pin         (i_synth_enable_pin),
      .i_single_ended_ref_pin     (i_single_ended_ref_pin),
      .i_clock_config_pin_a       (i_clock_config_pin_a),
      .i_clock_config_pin_b       (i_clock_config_pin_b),
      .i_osc_fast                 (i_osc_fast),
      .o_synth_enable             (o_synth_enable),
      .o_single_ended_ref_select  (o_single_ended_ref_select),
      .o_first_refout_select      (o_first_refout_select),
      .o_second_refout_select     (o_second_refout_select),
      .o_oscillator_trim_field    (o_oscillator_trim_field),
      .o_synth_reset_bit          (o_synth_reset_bit),
      .o_osc_calibration_complete (o_osc_calibration_complete)
   );

   // 25 MHz core clock
   initial i_core_clk = 1'b0;
   always #20 i_core_clk = ~i_core_clk;

   // oscillator model: fast once trim passes target, one cycle behind the trim
   always @(posedge i_core_clk) begin
      i_osc_fast <= (o_oscillator_trim_field > TARGET);
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : complete_run

   // one-cycle write strobe, returns once the effect has landed
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_core_clk);
      i_reg_wr    <= 1'b1;
      i_reg_addr  <= a;
      i_reg_wdata <= d;
      @(posedge i_core_clk);
      i_reg_wr    <= 1'b0;
      @(posedge i_core_clk);
      #1;
   endtask : wr

   // one-cycle read strobe, data taken after the registered answer
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_core_clk);
      i_reg_rd   <= 1'b1;
      i_reg_addr <= a;
      @(posedge i_core_clk);
      i_reg_rd   <= 1'b0;
      @(posedge i_core_clk);
      #1;
      d = o_reg_rdata;
   endtask : rd

   // pins as {b, a, single_ended, enable}; outputs settle one cycle after sampling
   task automatic set_pins(input logic [3:0] p);
      @(posedge i_core_clk);
      i_synth_enable_pin     <= p[0];
      i_single_ended_ref_pin <= p[1];
      i_clock_config_pin_a   <= p[2];
      i_clock_config_pin_b   <= p[3];
      @(posedge i_core_clk);
      @(posedge i_core_clk);
      #1;
   endtask : set_pins

   task automatic check_ctrl(input logic en, input logic se, input logic [1:0] f,
                             input logic [1:0] s);
      check({7'h00, o_synth_enable}, {7'h00, en});
      check({7'h00, o_single_ended_ref_select}, {7'h00, se});
      check({6'h00, o_first_refout_select}, {6'h00, f});
      check({6'h00, o_second_refout_select}, {6'h00, s});
   endtask : check_ctrl

   // hang guard, well beyond the expected few hundred cycles
   initial begin
      repeat (20000) @(posedge i_core_clk);
      n_fail++;
      complete_run();
   end

   initial begin
      n_fail      = 0;
      comparisons = 0;
      i_reset     = 1'b1;
      i_reg_wr    = 1'b0;
      i_reg_rd    = 1'b0;
      i_reg_addr  = 8'h00;
      i_reg_wdata = 8'h00;
      i_synth_enable_pin     = 1'b0;
      i_single_ended_ref_pin = 1'b0;
      i_clock_config_pin_a   = 1'b0;
      i_clock_config_pin_b   = 1'b0;
      repeat (10) @(posedge i_core_clk);
      i_reset <= 1'b0;

      // reset values and an unmapped offset
      rd(`SOV_ADDR_PIN_OVERRIDE, rv);
      check(rv, 8'h00);
      rd(`SOV_ADDR_OSC_TRIM, rv);
      check(rv, 8'h00);
      rd(`SOV_ADDR_RESET_CTRL, rv);
      check(rv, 8'h00);
      rd(`SOV_ADDR_CAL_CTRL, rv);
      check(rv, 8'h40);
      rd(`SOV_ADDR_CAL_STATUS, rv);
      check(rv, 8'h00);
      rd(8'h5A, rv);
      check(rv, 8'h00);
      $display("test reset_values done");

      // pin mode, with register fields loaded that must stay ignored
      wr(`SOV_ADDR_PIN_OVERRIDE, 8'h3E);
      for (int j = 0; j < 16; j++) begin
         set_pins(j[3:0]);
         check_ctrl(j[0], j[1], j[3:2], (j[2] & j[3]) ? 2'h1 : 2'h0);
      end
      $display("test pin_mode done");

      // register mode: every output code, pins held all high
      set_pins(4'hF);
      for (int k = 0; k < 16; k++) begin
         rv = {1'b1, 1'b0, k[3:2], k[1:0], k[0] ^ k[2], ~k[1]};
         wr(`SOV_ADDR_PIN_OVERRIDE, rv);
         check_ctrl(~k[1], k[0] ^ k[2], k[1:0], (k[1:0] == 2'h0) ? 2'h0 : k[3:2]);
         rd(`SOV_ADDR_PIN_OVERRIDE, rv);
         check(rv, {1'b1, 1'b0, k[3:2], k[1:0], k[0] ^ k[2], ~k[1]});
      end
      wr(`SOV_ADDR_PIN_OVERRIDE, 8'h00);
      check_ctrl(1'b1, 1'b1, 2'h3, 2'h1);
      $display("test register_mode done");

      // calibration run after reset release
      wr(`SOV_ADDR_RESET_CTRL, 8'h01);
      check({7'h00, o_synth_reset_bit}, 8'h01);
      check({7'h00, o_osc_calibration_complete}, 8'h00);
      wr(`SOV_ADDR_CAL_CTRL, 8'h31);
      wr(`SOV_ADDR_RESET_CTRL, 8'h00);
      check({7'h00, o_synth_reset_bit}, 8'h00);
      check({7'h00, o_osc_calibration_complete}, 8'h00);
      // no trim access until the flag is up; flag looked at once settled
      for (int i = 0; i < 400 && o_osc_calibration_complete !== 1'b1; i++) begin
         @(posedge i_core_clk);
         #1;
      end
      check({7'h00, o_osc_calibration_complete}, 8'h01);
      @(posedge i_core_clk);
      #1;
      check({1'b0, o_oscillator_trim_field}, {1'b0, TARGET});
      rd(`SOV_ADDR_CAL_STATUS, rv);
      check(rv, 8'h01);
      rd(`SOV_ADDR_OSC_TRIM, rv);
      check(rv, {1'b0, TARGET});
      $display("test calibration done");

      // release with calibration disabled: flag at once, trim untouched
      wr(`SOV_ADDR_RESET_CTRL, 8'h01);
      wr(`SOV_ADDR_CAL_CTRL, 8'h30);
      wr(`SOV_ADDR_RESET_CTRL, 8'h00);
      check({7'h00, o_osc_calibration_complete}, 8'h01);
      check({1'b0, o_oscillator_trim_field}, {1'b0, TARGET});
      $display("test calibration_skipped done");

      // run aborted by the reset bit never reports completion
      wr(`SOV_ADDR_RESET_CTRL, 8'h01);
      wr(`SOV_ADDR_CAL_CTRL, 8'h31);
      wr(`SOV_ADDR_RESET_CTRL, 8'h00);
      wr(`SOV_ADDR_RESET_CTRL, 8'h01);
      repeat (100) @(posedge i_core_clk);
      #1;
      check({7'h00, o_osc_calibration_complete}, 8'h00);
      $display("test calibration_abort done");

      // trim rewrite, driven with calibration off and the flag up
      wr(`SOV_ADDR_CAL_CTRL, 8'h30);
      wr(`SOV_ADDR_RESET_CTRL, 8'h00);
      check({7'h00, o_osc_calibration_complete}, 8'h01);
      wr(`SOV_ADDR_OSC_TRIM, 8'h2A);
      check({1'b0, o_oscillator_trim_field}, 8'h2A);
      rd(`SOV_ADDR_OSC_TRIM, rv);
      check(rv, 8'h2A);
      $display("test trim_rewrite done");

      complete_run();
   end

endmodule : tb_sov_synth_ctrl
